// ==== core/fifo_flags_pkg.sv ====
// Shared constants for the read-side flag FIFO and its storage array
package fifo_flags_pkg;

    // Default build sizes
    localparam int unsigned DEF_DATA_W        = 8;
    localparam int unsigned DEF_DEPTH         = 16;

    // Default read mode: 0 standard, 1 fall-through
    localparam bit          DEF_FALL_THROUGH  = 1'b0;

    // Words added to usable depth by the fall-through output stages
    localparam int unsigned FALL_THROUGH_GAIN = 2;

    // Level at which the almost flags trip: one word left or one slot left
    localparam int unsigned ALMOST_LEVEL      = 1;

    // Handshake flag slots, used as bit positions in the option vectors
    localparam int unsigned HS_NUM            = 4;
    localparam int unsigned HS_VALID          = 0;
    localparam int unsigned HS_UNDER          = 1;
    localparam int unsigned HS_ACK            = 2;
    localparam int unsigned HS_OVER           = 3;

    // Default handshake options: all present, all active high
    localparam logic [3:0]  DEF_HS_PRESENT    = 4'hf;
    localparam logic [3:0]  DEF_HS_ACT_LOW    = 4'h0;

    // Values after reset
    localparam logic        RST_EMPTY         = 1'b1;
    localparam logic        RST_AEMPTY        = 1'b0;
    localparam logic        RST_FULL          = 1'b0;
    localparam logic        RST_AFULL         = 1'b0;
    localparam logic        RST_VALID         = 1'b0;

endpackage : fifo_flags_pkg

// ==== core/fifo_read_flags.sv ====
// Common-clock FIFO with standard and fall-through read and status flags
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module fifo_read_flags
    import fifo_flags_pkg::*;
#(
    parameter int unsigned      DATA_W            = DEF_DATA_W,
    parameter int unsigned      DEPTH             = DEF_DEPTH,
    parameter bit               FALL_THROUGH_MODE = DEF_FALL_THROUGH,
    parameter logic [HS_NUM-1:0] HS_PRESENT       = DEF_HS_PRESENT,
    parameter logic [HS_NUM-1:0] HS_ACT_LOW       = DEF_HS_ACT_LOW
)(
    // Clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rstn,
    // Write side
    input  wire logic              i_wr_en,
    input  wire logic [DATA_W-1:0] i_wr_data,
    output logic                   o_full,
    output logic                   o_almost_full,
    output logic                   o_wr_ack,
    output logic                   o_overflow,
    // Read side
    input  wire logic              i_rd_en,
    output logic      [DATA_W-1:0] o_rd_data,
    output logic                   o_valid,
    output logic                   o_empty,
    output logic                   o_almost_empty,
    output logic                   o_underflow
);

    // Address and occupancy widths; occupancy has room for the two stages
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = AW + 2;

    // Pointer wrap point and flag levels at the occupancy width
    localparam logic [AW-1:0] LAST_ADDR  = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL_LVL   = CW'(DEPTH);
    localparam logic [CW-1:0] AFULL_LVL  = CW'(DEPTH - ALMOST_LEVEL);
    localparam logic [CW-1:0] AEMPTY_LVL = CW'(ALMOST_LEVEL);

    // Usable depth as seen by the reader, for reference by integrators
    localparam int unsigned USABLE_DEPTH =
        FALL_THROUGH_MODE ? DEPTH + FALL_THROUGH_GAIN : DEPTH;

    // All block state in one record
    typedef struct packed {
        logic [AW-1:0]     wptr;       // Next array slot to write
        logic [AW-1:0]     rptr;       // Next array slot to read
        logic [CW-1:0]     count;      // Words held in the array
        logic [DATA_W-1:0] stage_data; // Fall-through middle stage
        logic              stage_v;    // Middle stage holds a word
        logic [DATA_W-1:0] out_data;   // Word driven on read data
        logic              out_v;      // Output register holds a word
        logic              empty;      // Registered empty flag
        logic              aempty;     // Registered almost-empty flag
        logic              full;       // Registered full flag
        logic              afull;      // Registered almost-full flag
        logic [HS_NUM-1:0] hs;         // Handshake flags, active high
    } state_s;

    // Reset image of the state
    localparam state_s STATE_RST = '{
        wptr:       '0,
        rptr:       '0,
        count:      '0,
        stage_data: '0,
        stage_v:    1'b0,
        out_data:   '0,
        out_v:      RST_VALID,
        empty:      RST_EMPTY,
        aempty:     RST_AEMPTY,
        full:       RST_FULL,
        afull:      RST_AFULL,
        hs:         '0
    };

    state_s            s_q;
    state_s            s_d;

    // Per-cycle decisions
    logic              wr_acc;     // Write accepted into the array
    logic              rd_acc;     // Read request honoured
    logic              rd_miss;    // Read request refused
    logic              mem_pop;    // Word leaves the array this cycle
    logic              out_load;   // Middle stage moves to the output
    logic              stage_free; // Middle stage can take a new word
    logic [CW-1:0]     held_d;     // Readable words after this edge
    logic [DATA_W-1:0] mem_rdata;  // Array word at the read pointer
    logic [HS_NUM-1:0] hs_out;     // Handshake flags at pin polarity

    // Flip-flop array holding the queued words
    fifo_store #(
        .DATA_W (DATA_W),
        .DEPTH  (DEPTH),
        .AW     (AW)
    ) u_store (
        .i_mclk  (i_mclk),
        .i_rstn  (i_rstn),
        .i_wr    (wr_acc),
        .i_waddr (s_q.wptr),
        .i_wdata (i_wr_data),
        .i_raddr (s_q.rptr),
        .o_rdata (mem_rdata)
    );

    // Next-state logic for pointers, stages and flags
    always_comb begin
        s_d        = s_q;
        out_load   = 1'b0;
        stage_free = 1'b0;

        // A write is only taken while the array has room
        wr_acc = i_wr_en & ~s_q.full;

        if (FALL_THROUGH_MODE) begin
            // Read consumes the word already shown on the output
            rd_acc  = i_rd_en & s_q.out_v;
            rd_miss = i_rd_en & ~s_q.out_v;
            // Middle stage refills the output when it is free or consumed
            out_load   = s_q.stage_v & (~s_q.out_v | rd_acc);
            stage_free = ~s_q.stage_v | out_load;
            // The array feeds the middle stage without any request
            mem_pop = (s_q.count != '0) & stage_free;
        end else begin
            // Read is honoured only when a word is held
            rd_acc  = i_rd_en & (s_q.count != '0);
            rd_miss = i_rd_en & (s_q.count == '0);
            mem_pop = rd_acc;
        end

        // Write pointer steps after each stored word
        if (wr_acc) begin
            s_d.wptr = (s_q.wptr == LAST_ADDR) ? '0
                                               : s_q.wptr + AW'(1);
        end

        // Read pointer steps once per word leaving the array
        if (mem_pop) begin
            s_d.rptr = (s_q.rptr == LAST_ADDR) ? '0
                                               : s_q.rptr + AW'(1);
        end

        // Occupancy: a write and a read together cancel out
        s_d.count = s_q.count + CW'(wr_acc) - CW'(mem_pop);

        if (FALL_THROUGH_MODE) begin
            // Middle stage takes the array head or empties into the output
            if (mem_pop) begin
                s_d.stage_data = mem_rdata;
                s_d.stage_v    = 1'b1;
            end else if (out_load) begin
                s_d.stage_v = 1'b0;
            end
            // Output register shows the oldest word until it is read
            if (out_load) begin
                s_d.out_data = s_q.stage_data;
                s_d.out_v    = 1'b1;
            end else if (rd_acc) begin
                s_d.out_v = 1'b0;
            end
        end else begin
            // Output register loads only on an honoured read
            if (rd_acc) begin
                s_d.out_data = mem_rdata;
            end
            // Valid marks the cycle after each honoured read only
            s_d.out_v = rd_acc;
        end

        // Readable words include the fall-through stages
        if (FALL_THROUGH_MODE) begin
            held_d = s_d.count + CW'(s_d.stage_v) + CW'(s_d.out_v);
        end else begin
            held_d = s_d.count;
        end

        // Empty follows the output word in fall-through, the array otherwise
        if (FALL_THROUGH_MODE) begin
            s_d.empty = ~s_d.out_v;
        end else begin
            s_d.empty = (s_d.count == '0);
        end

        // Almost-empty only at exactly one readable word
        s_d.aempty = (held_d == AEMPTY_LVL);

        // Full and almost-full follow the array occupancy
        s_d.full  = (s_d.count == FULL_LVL);
        s_d.afull = (s_d.count == AFULL_LVL);

        // Handshake flags, kept active high inside
        s_d.hs[HS_VALID] = s_d.out_v;
        s_d.hs[HS_UNDER] = rd_miss;
        s_d.hs[HS_ACK]   = wr_acc;
        s_d.hs[HS_OVER]  = i_wr_en & s_q.full;
    end

    // State register; one record for the whole block
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Optional handshake flags at the chosen polarity; absent ones drive 0
    for (genvar g = 0; g < HS_NUM; g++) begin : g_hs
        assign hs_out[g] = HS_PRESENT[g] ? (s_q.hs[g] ^ HS_ACT_LOW[g])
                                         : 1'b0;
    end

    // Write side status
    assign o_full        = s_q.full;
    assign o_almost_full = s_q.afull;
    assign o_wr_ack      = hs_out[HS_ACK];
    assign o_overflow    = hs_out[HS_OVER];

    // Read side status and data
    assign o_rd_data      = s_q.out_data;
    assign o_valid        = hs_out[HS_VALID];
    assign o_empty        = s_q.empty;
    assign o_almost_empty = s_q.aempty;
    assign o_underflow    = hs_out[HS_UNDER];

endmodule : fifo_read_flags

// ==== core/fifo_store.sv ====
// Flip-flop storage array with one write port and one indexed read port
`timescale 1ns/1ps
module fifo_store
    import fifo_flags_pkg::*;
#(
    parameter int unsigned DATA_W = DEF_DATA_W,
    parameter int unsigned DEPTH  = DEF_DEPTH,
    parameter int unsigned AW     = 4
)(
    // Clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rstn,
    // Write port
    input  wire logic              i_wr,
    input  wire logic [AW-1:0]     i_waddr,
    input  wire logic [DATA_W-1:0] i_wdata,
    // Read port
    input  wire logic [AW-1:0]     i_raddr,
    output logic      [DATA_W-1:0] o_rdata
);

    typedef struct packed {
        logic [DEPTH-1:0][DATA_W-1:0] cells;
    } store_s;

    store_s s_q;
    store_s s_d;

    // Write the addressed cell, all others hold
    always_comb begin
        s_d = s_q;
        if (i_wr) begin
            s_d.cells[i_waddr] = i_wdata;
        end
    end

    // Storage registers, cleared by reset
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Read is a plain mux over the cells; the caller registers it
    assign o_rdata = s_q.cells[i_raddr];

endmodule : fifo_store

// ==== test/fifo_flags_props.sv ====
// Concurrent checks on the standard-mode buffer ports, active-high flags
`timescale 1ns/1ps
module fifo_flags_props
    import fifo_flags_pkg::*;
#(
    parameter int unsigned DATA_W = DEF_DATA_W,
    parameter int unsigned DEPTH  = DEF_DEPTH,
    parameter bit          FALL_THROUGH_MODE = DEF_FALL_THROUGH
)(
    // Clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rstn,
    // Write side
    input  wire logic              i_wr_en,
    input  wire logic [DATA_W-1:0] i_wr_data,
    input  wire logic              o_full,
    input  wire logic              o_almost_full,
    input  wire logic              o_wr_ack,
    input  wire logic              o_overflow,
    // Read side
    input  wire logic              i_rd_en,
    input  wire logic [DATA_W-1:0] o_rd_data,
    input  wire logic              o_valid,
    input  wire logic              o_empty,
    input  wire logic              o_almost_empty,
    input  wire logic              o_underflow
);
    default clocking cb @(posedge i_mclk);
    endclocking
    // These checks describe standard mode only; off for fall-through builds
    default disable iff (!i_rstn || FALL_THROUGH_MODE);

    // Read side answers one cycle after the request
    a_read_valid: assert property (i_rd_en && !o_empty |=> o_valid)
        else $error("no valid after a read with data held");
    a_under_flag: assert property (i_rd_en && o_empty |=> o_underflow && !o_valid)
        else $error("refused read not flagged");
    a_data_hold: assert property (!o_valid |-> $stable(o_rd_data))
        else $error("read data moved without a read");
    a_last_read: assert property (o_almost_empty && i_rd_en && !i_wr_en |=> o_empty && o_valid)
        else $error("last read lacks valid or empty");

    // Empty and almost-empty follow the writes
    a_empty_hold: assert property (o_empty && !i_wr_en |=> o_empty)
        else $error("empty fell without a write");
    a_write_in: assert property (o_empty && i_wr_en |=> !o_empty && o_almost_empty)
        else $error("first word did not show one left");
    a_both_empty: assert property (o_empty && i_wr_en && i_rd_en |=> o_underflow)
        else $error("read beside first write not refused");

    // Write side flags
    a_write_ack: assert property (i_wr_en && !o_full |=> o_wr_ack && !o_overflow)
        else $error("accepted write not acknowledged");
    a_over_flag: assert property (i_wr_en && o_full |=> o_overflow && !o_wr_ack)
        else $error("write while full not flagged");
    a_full_step: assert property (o_almost_full && i_wr_en && !i_rd_en |=> o_full)
        else $error("full missing after last slot written");
    a_both_keep: assert property (i_wr_en && i_rd_en && !o_empty && !o_full
        |=> $stable({o_full, o_almost_full, o_empty, o_almost_empty}))
        else $error("flags moved on a paired read and write");
endmodule : fifo_flags_props

bind fifo_read_flags fifo_flags_props #(.DATA_W(DATA_W), .DEPTH(DEPTH),
    .FALL_THROUGH_MODE(FALL_THROUGH_MODE)) props_i (.*);

// ==== test/fifo_user_model.sv ====
// User-side model issuing reads and writes with a running data pattern
`timescale 1ns/1ps
module fifo_user_model
    import fifo_flags_pkg::*;
#(
    parameter int unsigned DATA_W = DEF_DATA_W
)(
    // Clock, reset and bench commands
    input  wire logic              i_mclk,
    input  wire logic              i_rstn,
    input  wire logic              i_want_wr,
    input  wire logic              i_want_rd,
    input  wire logic              i_full,
    // Requests toward the buffer
    output logic                   o_wr_en,
    output logic      [DATA_W-1:0] o_wr_data,
    output logic                   o_rd_en
);
    logic [DATA_W-1:0] word_q;

    // Requests follow commands; data bus shows garbage when not writing
    assign o_wr_en   = i_want_wr;
    assign o_rd_en   = i_want_rd;
    assign o_wr_data = o_wr_en ? word_q : ~word_q;

    // Next word only once the buffer took the current one
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            word_q <= '0;
        end else if (o_wr_en && !i_full) begin
            word_q <= word_q + DATA_W'(1);
        end
    end
endmodule : fifo_user_model

// ==== test/tb.sv ====
// Self-checking bench for the standard-mode and fall-through buffers at depth four
`timescale 1ns/1ps
module tb;
    import fifo_flags_pkg::*;
    localparam int unsigned DP = 4;
    logic       i_mclk, i_rstn, want_wr, want_rd, i_wr_en, i_rd_en;
    logic       o_full, o_almost_full, o_wr_ack, o_overflow;
    logic       o_valid, o_empty, o_almost_empty, o_underflow;
    logic [7:0] i_wr_data, o_rd_data, exp_rd;
    int         bad_count, checks;
    logic       ft_wr, ft_rd, ft_full, ft_af, ft_ack, ft_ovf;
    logic       ft_valid, ft_empty, ft_ae, ft_under;
    logic [7:0] ft_din, ft_dout;

    fifo_user_model #(.DATA_W(8)) fifo_user_model_i (.i_mclk(i_mclk),
        .i_rstn(i_rstn), .i_want_wr(want_wr), .i_want_rd(want_rd),
        .i_full(o_full), .o_wr_en(i_wr_en), .o_wr_data(i_wr_data),
        .o_rd_en(i_rd_en));
    fifo_read_flags #(.DATA_W(8), .DEPTH(DP)) fifo_read_flags_i (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_wr_en(i_wr_en),
        .i_wr_data(i_wr_data), .o_full(o_full), .o_almost_full(o_almost_full),
        .o_wr_ack(o_wr_ack), .o_overflow(o_overflow), .i_rd_en(i_rd_en),
        .o_rd_data(o_rd_data), .o_valid(o_valid), .o_empty(o_empty),
        .o_almost_empty(o_almost_empty), .o_underflow(o_underflow));
    // Second buffer built for fall-through reads, driven directly
    fifo_read_flags #(.DATA_W(8), .DEPTH(DP), .FALL_THROUGH_MODE(1'b1))
        fifo_read_flags_ft_i (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .i_wr_en(ft_wr), .i_wr_data(ft_din), .o_full(ft_full),
        .o_almost_full(ft_af), .o_wr_ack(ft_ack), .o_overflow(ft_ovf),
        .i_rd_en(ft_rd), .o_rd_data(ft_dout), .o_valid(ft_valid),
        .o_empty(ft_empty), .o_almost_empty(ft_ae),
        .o_underflow(ft_under));

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // One request cycle; returns just after the edge that took it
    task automatic cyc(input logic w, input logic r);
        want_wr <= w;
        want_rd <= r;
        @(posedge i_mclk);
        #1;
    endtask : cyc

    // Flags packed as empty, almost empty, full, almost full
    task automatic flags(input logic [3:0] exp);
        check("flags", {4'h0, o_empty, o_almost_empty, o_full, o_almost_full}, {4'h0, exp});
    endtask : flags

    task automatic t_under();
        flags(4'h8);
        cyc(1'b0, 1'b1);
        check("underflow", o_underflow, 1'b1);
        check("valid", o_valid, 1'b0);
        flags(4'h8);
        cyc(1'b0, 1'b0);
        check("underflow", o_underflow, 1'b0);
        $display("underflow test done");
    endtask : t_under

    task automatic t_fill();
        for (int i = 0; i < DP; i++) begin
            cyc(1'b1, 1'b0);
            check("wr_ack", o_wr_ack, 1'b1);
            flags({1'b0, i == 0, i == DP - 1, i == DP - 2});
        end
        cyc(1'b1, 1'b0);
        check("overflow", o_overflow, 1'b1);
        check("wr_ack", o_wr_ack, 1'b0);
        flags(4'h2);
        $display("fill test done");
    endtask : t_fill

    task automatic t_drain();
        for (int i = DP - 1; i >= 0; i--) begin
            cyc(1'b0, 1'b1);
            check("valid", o_valid, 1'b1);
            check("rd_data", o_rd_data, exp_rd);
            flags({i == 0, i == 1, 1'b0, i == DP - 1});
            exp_rd++;
        end
        cyc(1'b0, 1'b0);
        check("valid", o_valid, 1'b0);
        check("rd_data", o_rd_data, exp_rd - 8'h01);
        cyc(1'b0, 1'b1);
        check("underflow", o_underflow, 1'b1);
        check("rd_data", o_rd_data, exp_rd - 8'h01);
        $display("drain test done");
    endtask : t_drain

    task automatic t_both();
        cyc(1'b1, 1'b1);
        check("underflow", o_underflow, 1'b1);
        flags(4'h4);
        cyc(1'b1, 1'b0);
        cyc(1'b1, 1'b1);
        flags(4'h0);
        check("rd_data", o_rd_data, exp_rd);
        exp_rd++;
        repeat (2) begin
            cyc(1'b0, 1'b1);
            check("rd_data", o_rd_data, exp_rd);
            exp_rd++;
        end
        cyc(1'b0, 1'b0);
        flags(4'h8);
        $display("paired test done");
    endtask : t_both

    // One request cycle on the fall-through buffer
    task automatic ftc(input logic w, input logic r, input logic [7:0] d);
        ft_wr <= w;
        ft_rd <= r;
        ft_din <= d;
        @(posedge i_mclk);
        #1;
    endtask : ftc

    task automatic t_ft();
        ftc(1'b1, 1'b0, 8'h5a);
        check("ft_empty", ft_empty, 1'b1);
        ftc(1'b0, 1'b0, 8'h00);
        check("ft_empty", ft_empty, 1'b1);
        ftc(1'b0, 1'b0, 8'h00);
        check("ft_empty", ft_empty, 1'b0);
        check("ft_valid", ft_valid, 1'b1);
        check("ft_data", ft_dout, 8'h5a);
        check("ft_aempty", ft_ae, 1'b1);
        ftc(1'b0, 1'b1, 8'h00);
        check("ft_valid", ft_valid, 1'b0);
        check("ft_empty", ft_empty, 1'b1);
        ftc(1'b0, 1'b1, 8'h00);
        check("ft_underflow", ft_under, 1'b1);
        for (int i = 0; i < DP + 2; i++) begin
            ftc(1'b1, 1'b0, 8'(i));
            check("ft_wr_ack", ft_ack, 1'b1);
        end
        ftc(1'b1, 1'b0, 8'hee);
        check("ft_overflow", ft_ovf, 1'b1);
        for (int i = 0; i < DP + 2; i++) begin
            check("ft_valid", ft_valid, 1'b1);
            check("ft_data", ft_dout, 8'(i));
            ftc(1'b0, 1'b1, 8'h00);
        end
        check("ft_empty", ft_empty, 1'b1);
        $display("fall-through test done");
    endtask : t_ft

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // Clock at 20 MHz
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end

    // Watchdog: tests need well under 200 cycles
    initial begin
        #10000;
        bad_count++;
        print_verdict();
    end

    // Reset then the scenarios in turn
    initial begin
        i_rstn = 1'b0;
        want_wr = 1'b0;
        want_rd = 1'b0;
        ft_wr = 1'b0;
        ft_rd = 1'b0;
        ft_din = 8'h00;
        exp_rd = 8'h00;
        repeat (2) @(posedge i_mclk);
        i_rstn <= 1'b1;
        @(posedge i_mclk);
        #1;
        t_under();
        t_fill();
        t_drain();
        t_both();
        t_ft();
        print_verdict();
    end
endmodule : tb
